// ---- hw/irq_stack_pkg.sv ----
// Purpose: Shared constants and types for the interrupt and stack control block.
// Assumes: One core clock; all control pulses are synchronous to it.
// Notes: The top-of-RAM value is a plain default and may be changed per memory size.
package irq_stack_pkg;

    // Interrupt source bank geometry.
    localparam int SRC_COUNT = 8;
    localparam int VEC_W = 4;
    localparam logic [VEC_W-1:0] VECTOR_BASE = 4'h1; // Slot 0 belongs to reset.
    localparam logic [SRC_COUNT-1:0] LEVEL_TYPE_MASK = 8'h01; // Sources without a latch.

    // Stack pointer bytes in I/O space and their reset value.
    localparam logic [5:0] STACK_LOW_OFFSET = 6'h3d;
    localparam logic [5:0] STACK_HIGH_OFFSET = 6'h3e;
    localparam logic [15:0] TOP_OF_RAM = 16'h025f;
    localparam logic [15:0] SP_STEP = 16'h0001;
    localparam logic [15:0] SP_DOUBLE_STEP = 16'h0002;

    // Global enable position in the status flags register.
    localparam int GIE_BIT = 7;

    // Sequence lengths in core clock cycles, counting the starting cycle.
    localparam int ENTRY_CYCLES = 4;
    localparam int RETURN_CYCLES = 4;
    localparam int WAKE_EXTRA_CYCLES = 4;
    localparam logic [1:0] ENTRY_LAST = 2'(ENTRY_CYCLES - 2);
    localparam logic [1:0] RETURN_LAST = 2'(RETURN_CYCLES - 2);
    localparam logic [1:0] WAKE_LAST = 2'(WAKE_EXTRA_CYCLES - 1);
    localparam logic [1:0] CNT_ONE = 2'h1;

    // Pointer pair selection and addressing modes.
    localparam logic [1:0] PTR_SEL_X = 2'h0;
    localparam logic [1:0] PTR_SEL_Y = 2'h1;
    localparam logic [1:0] PTR_SEL_Z = 2'h2;
    typedef enum logic [1:0] {PTR_PLAIN, PTR_DISP, PTR_POSTINC, PTR_PREDEC} ptr_mode_type;

endpackage : irq_stack_pkg

// ---- hw/irq_src_if.sv ----
// Purpose: Carries pending requests and acknowledges between source bank and core.
// Assumes: Acknowledge is a one-hot pulse in the cycle an entry is taken.
// Notes: The bank resolves priority so the core sees only the winner.
`timescale 1ns/100ps
`default_nettype none
interface irq_src_if;
    import irq_stack_pkg::*;
    logic [SRC_COUNT-1:0] pending;
    logic [SRC_COUNT-1:0] ack;
    logic any;
    logic [VEC_W-1:0] winner_vec;
    modport bank (output pending, output any, output winner_vec, input ack);
    modport core (input pending, input any, input winner_vec, output ack);
endinterface : irq_src_if
`default_nettype wire

// ---- hw/irq_source_bank.sv ----
// Purpose: Latches flag-type requests, passes level-type ones, picks the winner.
// Assumes: Events and clears are one-cycle pulses on the core clock.
// Notes: A set arriving with a clear, hardware or software, is kept.
`timescale 1ns/100ps
`default_nettype none
module irq_source_bank
    import irq_stack_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [SRC_COUNT-1:0] src_event,
    input wire logic [SRC_COUNT-1:0] src_level,
    input wire logic [SRC_COUNT-1:0] src_enable,
    input wire logic [SRC_COUNT-1:0] flag_clear_w1,
    output logic [SRC_COUNT-1:0] src_flag,
    irq_src_if.bank src
);
    logic [SRC_COUNT-1:0] flag_r;

    // One flag per source; level-type sources never latch.
    genvar g;
    generate
        for (g = 0; g < SRC_COUNT; g++) begin : g_src
            always_ff @(posedge sys_clk) begin
                if (!rst_b || LEVEL_TYPE_MASK[g]) begin
                    flag_r[g] <= 1'b0;
                end else if (src_event[g]) begin
                    flag_r[g] <= 1'b1;
                end else if (src.ack[g] || flag_clear_w1[g]) begin
                    flag_r[g] <= 1'b0;
                end
            end
            // Level sources request only while the condition stands.
            assign src.pending[g] = src_enable[g] &
                (LEVEL_TYPE_MASK[g] ? src_level[g] : flag_r[g]);
        end
    endgenerate

    // Lowest slot wins, so scan downward and let the last hit stand.
    always_comb begin
        src.winner_vec = VECTOR_BASE;
        for (int i = SRC_COUNT - 1; i >= 0; i--) begin
            if (src.pending[i]) begin
                src.winner_vec = VEC_W'(i) + VECTOR_BASE;
            end
        end
    end

    assign src.any = |src.pending;
    assign src_flag = flag_r;
endmodule : irq_source_bank
`default_nettype wire

// ---- hw/pointer_address_unit.sv ----
// Purpose: Effective address and write-back value for the three data pointers.
// Assumes: The register file supplies current pointer pairs and takes write-back.
// Notes: Results appear one cycle after the request to keep outputs registered.
`timescale 1ns/100ps
`default_nettype none
module pointer_address_unit
    import irq_stack_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic ptr_req,
    input wire logic [1:0] ptr_sel,
    input wire ptr_mode_type ptr_mode,
    input wire logic [5:0] ptr_disp,
    input wire logic [15:0] ptr_x,
    input wire logic [15:0] ptr_y,
    input wire logic [15:0] ptr_z,
    output logic ptr_valid,
    output logic [15:0] ptr_eff_addr,
    output logic [15:0] ptr_new_value
);
    logic [15:0] base;

    // Pick the pair addressed by the request.
    always_comb begin
        case (ptr_sel)
            PTR_SEL_X: base = ptr_x;
            PTR_SEL_Y: base = ptr_y;
            PTR_SEL_Z: base = ptr_z;
            default: base = ptr_z;
        endcase
    end

    // Displacement, post-increment and pre-decrement forms.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ptr_valid <= 1'b0;
            ptr_eff_addr <= 16'h0000;
            ptr_new_value <= 16'h0000;
        end else begin
            ptr_valid <= ptr_req;
            ptr_new_value <= base;
            case (ptr_mode)
                PTR_DISP: ptr_eff_addr <= base + {10'h000, ptr_disp};
                PTR_POSTINC: begin
                    ptr_eff_addr <= base;
                    ptr_new_value <= base + SP_STEP;
                end
                PTR_PREDEC: begin
                    ptr_eff_addr <= base - SP_STEP;
                    ptr_new_value <= base - SP_STEP;
                end
                default: ptr_eff_addr <= base;
            endcase
        end
    end
endmodule : pointer_address_unit
`default_nettype wire

// ---- hw/irq_stack_ctrl.sv ----
// Purpose: Interrupt entry and return sequencing, stack pointer and data pointers.
// Assumes: The instruction sequencer stalls while stall is high and pulses ops.
// Notes: Stack memory answers a read one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// - Byte push stores, then pointer drops one.
// - Call or entry pushes address, pointer drops two.
// - Byte pop raises pointer one, returns byte.
// - Return pops two-byte address, pointer rises two.
// - Pointer bytes readable, writable, reset top-of-RAM.
// - Three 16-bit pointers: displacement, increment, decrement.
// - Taken only with own and global enable.
// - Lowest vector wins; reset, then request zero.
// - Entry clears global enable; handler may nest.
// - Handler return takes four cycles, sets enable.
// - Vectoring or writing one clears flag.
// - Disabled flags stay latched until served.
// - Level sources request only while present.
// - One program instruction runs after return.
// - Status flags never saved or restored.
// - Clear-enable op blocks even simultaneous requests.
// - Instruction after set-enable always executes first.
// - Entry takes four cycles, pushes counter.
// - Multi-cycle instruction finishes before entry.
// - Waking from sleep adds four cycles.
// - Runs on undivided core clock, fetch overlaps.
// - Global enable is status bit seven.
module irq_stack_ctrl
    import irq_stack_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_b,
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    input wire logic instr_boundary,
    input wire logic sleeping,
    input wire logic [15:0] pc_in,
    input wire logic op_push,
    input wire logic op_pop,
    input wire logic op_call,
    input wire logic op_ret,
    input wire logic op_return_from_handler,
    input wire logic [7:0] push_data,
    input wire logic gie_set_op,
    input wire logic gie_clear_op,
    input wire logic status_write,
    input wire logic [7:0] status_wdata,
    output logic global_enable,
    output logic stall,
    output logic pop_valid,
    output logic [7:0] pop_data,
    output logic entry_done,
    output logic [VEC_W-1:0] vector_index,
    output logic ret_done,
    output logic [15:0] ret_pc,
    output logic mem_wr,
    output logic mem_rd,
    output logic [15:0] mem_addr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    input wire logic [SRC_COUNT-1:0] src_event,
    input wire logic [SRC_COUNT-1:0] src_level,
    input wire logic [SRC_COUNT-1:0] src_enable,
    input wire logic [SRC_COUNT-1:0] flag_clear_w1,
    output logic [SRC_COUNT-1:0] src_flag,
    input wire logic ptr_req,
    input wire logic [1:0] ptr_sel,
    input wire ptr_mode_type ptr_mode,
    input wire logic [5:0] ptr_disp,
    input wire logic [15:0] ptr_x,
    input wire logic [15:0] ptr_y,
    input wire logic [15:0] ptr_z,
    output logic ptr_valid,
    output logic [15:0] ptr_eff_addr,
    output logic [15:0] ptr_new_value
);
    typedef enum {ST_IDLE, ST_WAKE, ST_ENTRY, ST_RETURN, ST_POPWAIT} seq_state_type;

    seq_state_type state_r;
    logic [1:0] cnt_r;
    logic [15:0] sp_r;
    logic gie_r;
    logic hold_r;
    logic is_irq_r;
    logic is_return_from_handler_r;
    logic [15:0] pc_saved_r;
    logic [7:0] ret_hi_r;
    logic [VEC_W-1:0] vec_r;
    logic take;
    logic idle;
    logic any_op;
    logic entry_last;
    logic return_last;

    irq_src_if src ();

    irq_source_bank u_bank (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .src_event(src_event),
        .src_level(src_level),
        .src_enable(src_enable),
        .flag_clear_w1(flag_clear_w1),
        .src_flag(src_flag),
        .src(src.bank)
    );

    pointer_address_unit u_ptr (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ptr_req(ptr_req),
        .ptr_sel(ptr_sel),
        .ptr_mode(ptr_mode),
        .ptr_disp(ptr_disp),
        .ptr_x(ptr_x),
        .ptr_y(ptr_y),
        .ptr_z(ptr_z),
        .ptr_valid(ptr_valid),
        .ptr_eff_addr(ptr_eff_addr),
        .ptr_new_value(ptr_new_value)
    );

    // Sequence decode shared by several processes.
    assign idle = (state_r == ST_IDLE);
    assign any_op = op_push | op_pop | op_call | op_ret | op_return_from_handler;
    assign entry_last = (state_r == ST_ENTRY) && (cnt_r == ENTRY_LAST);
    assign return_last = (state_r == ST_RETURN) && (cnt_r == RETURN_LAST);

    // Entry is only ever started at an instruction boundary, so a multi-cycle
    // instruction always completes first. Any enable change in this cycle
    // blocks it, which closes the race with the clear-enable op.
    assign take = idle && instr_boundary && !any_op && gie_r && src.any
        && !gie_clear_op
        && !gie_set_op
        && !status_write
        && !hold_r;

    // Maps a vector slot back to the index of its source.
    function automatic int vec_idx(input logic [VEC_W-1:0] v);
        vec_idx = int'(v - VECTOR_BASE);
    endfunction : vec_idx

    // Hardware acknowledge clears the winning flag as it vectors.
    always_comb begin
        src.ack = '0;
        if (take) begin
            src.ack[vec_idx(src.winner_vec)] = 1'b1;
        end
    end

    // The stall keeps the sequencer off the stack port during sequences.
    assign stall = !idle;
    assign global_enable = gie_r;

    // Stack memory port. Writes address the pointer register and reads the byte above it,
    // so the push writes at the old top before the pointer moves.
    always_comb begin
        mem_wr = 1'b0;
        mem_rd = 1'b0;
        mem_addr = sp_r;
        mem_wdata = push_data;
        case (state_r)
            ST_IDLE: begin
                if (op_push) begin
                    mem_wr = 1'b1;
                end else if (op_pop) begin
                    mem_rd = 1'b1;
                    mem_addr = sp_r + SP_STEP;
                end
            end
            ST_ENTRY: begin
                if (cnt_r < ENTRY_LAST) begin
                    mem_wr = 1'b1;
                    mem_wdata = (cnt_r == 2'h0) ? pc_saved_r[7:0] : pc_saved_r[15:8];
                end
            end
            ST_RETURN: begin
                if (cnt_r < RETURN_LAST) begin
                    mem_rd = 1'b1;
                    mem_addr = sp_r + SP_STEP;
                end
            end
            default: begin
                mem_wr = 1'b0;
            end
        endcase
    end

    // Stack pointer; software writes a byte at a time, sequences move it.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            sp_r <= TOP_OF_RAM;
        end else if (io_wr && io_addr == STACK_LOW_OFFSET) begin
            sp_r[7:0] <= io_wdata;
        end else if (io_wr && io_addr == STACK_HIGH_OFFSET) begin
            sp_r[15:8] <= io_wdata;
        end else if (idle && op_push) begin
            sp_r <= sp_r - SP_STEP;
        end else if (idle && op_pop) begin
            sp_r <= sp_r + SP_STEP;
        end else if (state_r == ST_ENTRY && cnt_r < ENTRY_LAST) begin
            sp_r <= sp_r - SP_STEP;
        end else if (state_r == ST_RETURN && cnt_r < RETURN_LAST) begin
            sp_r <= sp_r + SP_STEP;
        end
    end

    // Register read port; unused offsets read as zero.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            io_rdata <= 8'h00;
        end else if (io_rd) begin
            case (io_addr)
                STACK_LOW_OFFSET: io_rdata <= sp_r[7:0];
                STACK_HIGH_OFFSET: io_rdata <= sp_r[15:8];
                default: io_rdata <= 8'h00;
            endcase
        end
    end

    // Global enable. Only bit seven of a status write reaches this block; the
    // other status flags are never copied to the stack. Earlier branches win.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            gie_r <= 1'b0;
        end else if (take) begin
            gie_r <= 1'b0;
        end else if (gie_clear_op) begin
            gie_r <= 1'b0;
        end else if (gie_set_op) begin
            gie_r <= 1'b1;
        end else if (status_write) begin
            gie_r <= status_wdata[GIE_BIT];
        end else if (return_last && is_return_from_handler_r) begin
            gie_r <= 1'b1;
        end
    end

    // One-instruction hold after set-enable or handler return; it drops at
    // the boundary that ends the instruction allowed to run.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            hold_r <= 1'b0;
        end else if (gie_set_op) begin
            hold_r <= 1'b1;
        end else if (return_last && is_return_from_handler_r) begin
            hold_r <= 1'b1;
        end else if (instr_boundary) begin
            hold_r <= 1'b0;
        end
    end

    // Sequencer for entry, call, return and pop. A sleeping core spends the
    // extra wake cycles before the push begins.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_r <= ST_IDLE;
            cnt_r <= 2'h0;
            is_irq_r <= 1'b0;
            is_return_from_handler_r <= 1'b0;
            pc_saved_r <= 16'h0000;
            vec_r <= '0;
        end else begin
            case (state_r)
                ST_IDLE: begin
                    cnt_r <= 2'h0;
                    if (take) begin
                        pc_saved_r <= pc_in;
                        vec_r <= src.winner_vec;
                        is_irq_r <= 1'b1;
                        state_r <= sleeping ? ST_WAKE : ST_ENTRY;
                    end else if (op_call) begin
                        pc_saved_r <= pc_in;
                        vec_r <= '0;
                        is_irq_r <= 1'b0;
                        state_r <= ST_ENTRY;
                    end else if (op_ret || op_return_from_handler) begin
                        is_return_from_handler_r <= op_return_from_handler;
                        state_r <= ST_RETURN;
                    end else if (op_pop) begin
                        state_r <= ST_POPWAIT;
                    end
                end
                ST_WAKE: begin
                    cnt_r <= cnt_r + CNT_ONE;
                    if (cnt_r == WAKE_LAST) begin
                        cnt_r <= 2'h0;
                        state_r <= ST_ENTRY;
                    end
                end
                ST_ENTRY: begin
                    cnt_r <= cnt_r + CNT_ONE;
                    if (entry_last) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_RETURN: begin
                    cnt_r <= cnt_r + CNT_ONE;
                    if (return_last) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_POPWAIT: state_r <= ST_IDLE;
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // Returned data: high byte lies nearer the top, low byte follows.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            ret_hi_r <= 8'h00;
            ret_pc <= 16'h0000;
            pop_data <= 8'h00;
        end else begin
            if (state_r == ST_RETURN && cnt_r == CNT_ONE) begin
                ret_hi_r <= mem_rdata;
            end
            if (return_last) begin
                ret_pc <= {ret_hi_r, mem_rdata};
            end
            if (state_r == ST_POPWAIT) begin
                pop_data <= mem_rdata;
            end
        end
    end

    // Completion pulses, each one cycle wide, all from flip-flops.
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            entry_done <= 1'b0;
            ret_done <= 1'b0;
            pop_valid <= 1'b0;
            vector_index <= '0;
        end else begin
            entry_done <= entry_last;
            ret_done <= return_last;
            pop_valid <= (state_r == ST_POPWAIT);
            if (entry_last) begin
                vector_index <= vec_r;
            end
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_b);

    push_step_a: assert property (idle && op_push && !io_wr
        |=> sp_r == $past(sp_r) - SP_STEP)
        else $error("push did not lower pointer by one");
    entry_step_a: assert property ($rose(state_r == ST_ENTRY) && !io_wr
        |-> ##2 sp_r == $past(sp_r, 2) - SP_DOUBLE_STEP)
        else $error("entry did not lower pointer by two");
    pop_step_a: assert property (idle && op_pop && !io_wr
        |=> sp_r == $past(sp_r) + SP_STEP ##1 pop_valid)
        else $error("pop did not raise pointer or deliver byte");
    ret_step_a: assert property (idle && op_ret && !take
        |-> ##4 ret_done && sp_r == $past(sp_r, 4) + SP_DOUBLE_STEP)
        else $error("return did not raise pointer by two in time");
    sp_reset_a: assert property ($rose(rst_b) |-> sp_r == TOP_OF_RAM)
        else $error("stack pointer not at top of RAM after reset");
    take_gate_a: assert property (src.ack != '0
        |-> gie_r && (src.ack & src_enable) == src.ack)
        else $error("entry taken without both enables");
    entry_gie_a: assert property (take |=> !gie_r)
        else $error("entry left global enable set");
    return_from_handler_time_a: assert property (idle && op_return_from_handler && !gie_clear_op && !gie_set_op
        && !status_write |-> ##4 ret_done && gie_r)
        else $error("handler return not done in four cycles");
    return_from_handler_hold_a: assert property (ret_done && is_return_from_handler_r |-> hold_r && !take)
        else $error("interrupt served directly after return");
    cli_block_a: assert property (gie_clear_op |-> !take ##1 !gie_r)
        else $error("entry taken with clear-enable op");
    sei_hold_a: assert property (gie_set_op |-> !take ##1 hold_r)
        else $error("entry taken before instruction after set-enable");
    entry_time_a: assert property (take && !sleeping |-> ##4 entry_done)
        else $error("entry not done in four cycles");
    wake_time_a: assert property (take && sleeping |-> ##4 !entry_done ##4 entry_done)
        else $error("wake entry not extended by four cycles");
    boundary_a: assert property (!stall && !any_op ##1 stall |-> $past(instr_boundary))
        else $error("entry started inside an instruction");
endmodule : irq_stack_ctrl
`default_nettype wire

// ---- tb/stack_mem_model.sv ----
// Purpose: Stack data memory that sits behind the stack port of the block.
// Assumes: Read data is due in the cycle after the read strobe.
// Notes: Outside that cycle the data lines show the inverse of their last value.
`timescale 1ns/100ps
`default_nettype none
module stack_mem_model (
    input wire logic sys_clk,
    input wire logic mem_wr,
    input wire logic mem_rd,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:1023];
    // Read data stands for one cycle only, so a late sample sees a wrong byte.
    always @(posedge sys_clk) begin
        if (mem_wr) begin
            mem[mem_addr[9:0]] <= mem_wdata;
        end
        mem_rdata <= mem_rd ? mem[mem_addr[9:0]] : ~mem_rdata;
    end
    // Give the data lines a defined level before the first read.
    initial begin
        mem_rdata = 8'h00;
    end
endmodule : stack_mem_model
`default_nettype wire

// ---- tb/tb_irq_stack_ctrl.sv ----
// Purpose: Self-checking bench for the interrupt and stack control block.
// Assumes: Inputs move by non-blocking assignment at the rising edge.
// Notes: Latencies count edges from the take edge to the done pulse.
`timescale 1ns/100ps
`default_nettype none
module tb_irq_stack_ctrl
    import irq_stack_pkg::*;
;
    logic sys_clk = 1'b0, rst_b = 1'b0, io_wr = 1'b0, io_rd = 1'b0, slp = 1'b0, preq = 1'b0;
    logic [5:0] io_addr = 6'h00;
    logic [7:0] io_wdata = 8'h00, push_data = 8'ha5, ev = 8'h00, lvl = 8'h00, clr = 8'h00;
    logic [7:0] en = 8'h25, sw = 8'h80, io_rdata, pop_data, mem_wdata, mem_rdata, flag;
    logic [4:0] ops = 5'h00;
    logic [3:0] g = 4'h0, vi;
    logic [15:0] pb = 16'h0100, ret_pc, maddr, eff, nv;
    logic ge, stall, pv, ed, rd, mwr, mrd, pval;
    ptr_mode_type pm = PTR_PLAIN;
    int num_errors = 0, n_checks = 0;
    wire [2:0] dn = {rd, ed, pv};
    // Free-running core clock.
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    irq_stack_ctrl dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .io_addr(io_addr), .io_wr(io_wr),
        .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata), .instr_boundary(g[2]),
        .sleeping(slp), .pc_in(16'h1234), .op_push(ops[0]), .op_pop(ops[1]), .op_call(ops[2]),
        .op_ret(ops[3]), .op_return_from_handler(ops[4]), .push_data(push_data), .gie_set_op(g[0]),
        .gie_clear_op(g[1]), .status_write(g[3]), .status_wdata(sw), .global_enable(ge),
        .stall(stall), .pop_valid(pv), .pop_data(pop_data), .entry_done(ed), .vector_index(vi),
        .ret_done(rd), .ret_pc(ret_pc), .mem_wr(mwr), .mem_rd(mrd), .mem_addr(maddr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .src_event(ev), .src_level(lvl),
        .src_enable(en), .flag_clear_w1(clr), .src_flag(flag), .ptr_req(preq),
        .ptr_sel(PTR_SEL_Y), .ptr_mode(pm), .ptr_disp(6'h05), .ptr_x(~pb), .ptr_y(pb),
        .ptr_z(16'h0300), .ptr_valid(pval), .ptr_eff_addr(eff), .ptr_new_value(nv));
    stack_mem_model mem_u (.sys_clk(sys_clk), .mem_wr(mwr), .mem_rd(mrd), .mem_addr(maddr),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    // One register access; read data is sampled after the taking edge.
    task automatic io(input logic wr, input logic [5:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= wr;
        io_rd <= !wr;
        @(posedge sys_clk);
        io_wr <= 1'b0;
        io_rd <= 1'b0;
        #1;
    endtask : io
    // One-cycle pulse of ops, events, clears and {status, boundary, clear, set}.
    task automatic pl(input logic [4:0] o, input logic [7:0] e, input logic [7:0] c,
                      input logic [3:0] gg);
        @(posedge sys_clk);
        ops <= o;
        ev <= e;
        clr <= c;
        g <= gg;
        @(posedge sys_clk);
        ops <= 5'h00;
        ev <= 8'h00;
        clr <= 8'h00;
        g <= 4'h0;
        #1;
    endtask : pl
    task automatic bd(input logic [3:0] gg, input logic t);
        pl(5'h00, 8'h00, 8'h00, gg);
        chk("stall", 16'(t), 16'(stall));
    endtask : bd
    // Bounded wait for a done pulse, then its distance from the take edge.
    task automatic wt(input int k, input int lat);
        int n;
        for (n = 0; n < 20 && dn[k] !== 1'b1; n++) @(posedge sys_clk) #1;
        chk("latency", 16'(lat), 16'(n));
    endtask : wt
    // Main sequence.
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_b <= 1'b1;
        io(1'b0, STACK_HIGH_OFFSET, 8'h00);
        chk("stack_high", 16'(TOP_OF_RAM[15:8]), 16'(io_rdata));
        io(1'b1, STACK_LOW_OFFSET, 8'h00);
        io(1'b1, STACK_HIGH_OFFSET, 8'h01);
        io(1'b0, 6'h10, 8'h00);
        chk("unmapped", 16'h00, 16'(io_rdata));
        pl(5'h01, 8'h00, 8'h00, 4'h0);
        io(1'b0, STACK_LOW_OFFSET, 8'h00);
        chk("stack_low", 16'hff, 16'(io_rdata));
        pl(5'h02, 8'h00, 8'h00, 4'h0);
        wt(0, 1);
        chk("pop", 16'ha5, 16'(pop_data));
        pl(5'h04, 8'h00, 8'h00, 4'h0);
        wt(1, 3);
        io(1'b0, STACK_LOW_OFFSET, 8'h00);
        chk("stack_low", 16'hfe, 16'(io_rdata));
        pl(5'h08, 8'h00, 8'h00, 4'h0);
        wt(2, 3);
        chk("ret_pc", 16'h1234, ret_pc);
        io(1'b0, STACK_LOW_OFFSET, 8'h00);
        chk("stack_low", 16'h00, 16'(io_rdata));
        $display("test stack done");
        pl(5'h00, 8'h26, 8'h00, 4'h0);
        chk("flags", 16'h26, 16'(flag));
        bd(4'h4, 1'b0);
        bd(4'h5, 1'b0);
        bd(4'h4, 1'b0);
        bd(4'h4, 1'b1);
        wt(1, 3);
        chk("vector", 16'h3, 16'(vi));
        chk("gie", 16'h0, 16'(ge));
        chk("flags", 16'h22, 16'(flag));
        pl(5'h10, 8'h00, 8'h00, 4'h0);
        wt(2, 3);
        chk("gie", 16'h1, 16'(ge));
        bd(4'h4, 1'b0);
        bd(4'h4, 1'b1);
        wt(1, 3);
        chk("vector", 16'h6, 16'(vi));
        pl(5'h00, 8'h20, 8'h02, 4'h8);
        chk("flags", 16'h20, 16'(flag));
        bd(4'h6, 1'b0);
        chk("gie", 16'h0, 16'(ge));
        @(posedge sys_clk);
        lvl <= 8'h01;
        slp <= 1'b1;
        pl(5'h00, 8'h00, 8'h00, 4'h8);
        bd(4'h4, 1'b1);
        wt(1, 7);
        chk("vector", 16'h1, 16'(vi));
        pl(5'h00, 8'h00, 8'h00, 4'h8);
        chk("gie", 16'h1, 16'(ge));
        @(posedge sys_clk);
        sw <= 8'h7f;
        pl(5'h00, 8'h00, 8'h00, 4'h8);
        chk("gie", 16'h0, 16'(ge));
        $display("test interrupts done");
        for (int m = 0; m < 4; m++) begin
            @(posedge sys_clk);
            pm <= ptr_mode_type'(m);
            preq <= 1'b1;
            @(posedge sys_clk);
            preq <= 1'b0;
            #1;
            chk("valid", 16'h1, 16'(pval));
            chk("eff", 16'h0100 + (m == 1 ? 16'h5 : 16'h0) - 16'(m == 3), eff);
            chk("new", 16'h0100 + 16'(m == 2) - 16'(m == 3), nv);
        end
        $display("test pointers done");
        end_sim();
    end
    // Watchdog against a hung handshake.
    initial begin
        #50000;
        num_errors++;
        end_sim();
    end
endmodule : tb_irq_stack_ctrl
`default_nettype wire
